// File: design/rcf_pkg.sv
// Package for the NMI and reset cause flag registers
package rcf_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] NMI_CAUSE_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] RST_CAUSE_OFS = 4'h4;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int NMI_WDT_BIT = 0;
    localparam int NMI_PIN_BIT = 1;
    localparam int NMI_W = 2;
    localparam int RST_PON_BIT = 0;
    localparam int RST_PIN_BIT = 1;
    localparam int RST_WDT_BIT = 2;
    localparam int RST_ZERO_BIT = 3;
    localparam int RST_CORE_BIT = 4;
    localparam int RST_W = 5;

    // Bits that hold a flag; bit 3 is write-zero and always reads zero
    localparam logic [RST_W-1:0] RST_FLAG_MASK = 5'h17;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [NMI_W-1:0] NMI_CAUSE_RST = 2'h0;
    localparam logic [RST_W-1:0] RST_CAUSE_POR = 5'h01;

    // ****************************************
    // Bus answers
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One-cycle pulses from the reset controller naming the reset source
    typedef struct packed {
        logic core_req;
        logic watchdog;
        logic pin;
    } rcf_rst_src_t;

endpackage // rcf_pkg

// File: design/rcf_cause_flags.sv
// NMI cause and reset cause flag registers with an AXI4-Lite slave
`timescale 1ns/100ps

// Behaviour
// R01 - A watchdog NMI sets NMI cause bit 0 and an NMI pin event sets NMI cause bit 1.
// R02 - A read of the NMI cause register returns the flags and then clears both to zero.
// R03 - The NMI cause register is read-only, its flags reset to zero, bits 31 to 2 read zero.
// R04 - Flags at 4 core, 2 watchdog, 1 pin, 0 power-on; 0 clears; bit 3 gets 0; 31:5 read 0.
// R05 - Only power-on reset initialises the reset cause register; later resets leave it alone.
// R06 - Writing one to a reset cause flag leaves it unchanged; only reset sources set flags.
module rcf_cause_flags (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic por_n,
    input wire logic wdt_nmi,
    input wire logic nmi_pin,
    input wire rcf_pkg::rcf_rst_src_t rst_src,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    import rcf_pkg::*;

    // ****************************************
    // NMI pin synchroniser
    // ****************************************
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_s3_r;
    logic pin_lvl_r;
    logic pin_agree;
    logic pin_rise;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
            pin_lvl_r <= 1'b0;
        end
        else
        begin
            pin_s1_r <= nmi_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_agree)
                pin_lvl_r <= pin_s3_r;
        end
    end

    // A change counts only once two stages agree, so a one-cycle glitch never raises a flag
    assign pin_agree = (pin_s2_r == pin_s3_r);
    assign pin_rise = pin_agree && pin_s3_r && !pin_lvl_r;

    // ****************************************
    // Bus handshakes and decode
    // ****************************************
    logic awready_r;
    logic wready_r;
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic aw_hs;
    logic w_hs;
    logic b_hs;
    logic ar_hs;
    logic r_hs;
    logic do_wr;
    logic wr_nmi;
    logic wr_rst;
    logic wr_lane0;
    logic rd_nmi;
    logic rd_rst;
    logic rd_ok;
    logic wr_ok;
    logic [ADDR_W-1:0] raddr;
    logic [31:0] rd_data;

    assign aw_hs = s_axi_awvalid && awready_r;
    assign w_hs = s_axi_wvalid && wready_r;
    assign b_hs = bvalid_r && s_axi_bready;
    assign ar_hs = s_axi_arvalid && arready_r;
    assign r_hs = rvalid_r && s_axi_rready;
    assign do_wr = aw_held_r && w_held_r && !bvalid_r;

    // Only the aligned word address is decoded; upper address bits must be zero
    assign raddr = s_axi_araddr[ADDR_W-1:0];
    assign rd_nmi = (s_axi_araddr[31:ADDR_W] == '0) && (raddr == NMI_CAUSE_OFS);
    assign rd_rst = (s_axi_araddr[31:ADDR_W] == '0) && (raddr == RST_CAUSE_OFS);
    assign rd_ok = rd_nmi || rd_rst;
    assign wr_nmi = (waddr_r == NMI_CAUSE_OFS);
    assign wr_rst = (waddr_r == RST_CAUSE_OFS);
    assign wr_ok = wr_nmi || wr_rst;
    assign wr_lane0 = do_wr && wr_rst && wstrb_r[0];

    // ****************************************
    // NMI cause register
    // ****************************************
    logic [NMI_W-1:0] nmi_r;
    logic [NMI_W-1:0] nmi_set;
    logic [NMI_W-1:0] nmi_nxt;
    logic nmi_rd_clr;

    assign nmi_set[NMI_WDT_BIT] = wdt_nmi; // R01
    assign nmi_set[NMI_PIN_BIT] = pin_rise; // R01
    // A read takes the current value, then clears; a cause in the same cycle survives
    assign nmi_rd_clr = ar_hs && rd_nmi; // R02
    assign nmi_nxt = (nmi_rd_clr ? NMI_CAUSE_RST : nmi_r) | nmi_set; // R02

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            nmi_r <= NMI_CAUSE_RST; // R03
        else
            nmi_r <= nmi_nxt;
    end

    // ****************************************
    // Reset cause register
    // ****************************************
    logic [RST_W-1:0] rst_r;
    logic [RST_W-1:0] rst_set;
    logic [RST_W-1:0] rst_keep;
    logic [RST_W-1:0] rst_nxt;

    assign rst_set[RST_PON_BIT] = 1'b0;
    assign rst_set[RST_PIN_BIT] = rst_src.pin; // R04
    assign rst_set[RST_WDT_BIT] = rst_src.watchdog; // R04
    assign rst_set[RST_ZERO_BIT] = 1'b0;
    assign rst_set[RST_CORE_BIT] = rst_src.core_req; // R04
    // Written ones are ANDed in, so they can only keep a flag, never raise it
    assign rst_keep = wr_lane0 ? wdata_r[RST_W-1:0] : {RST_W{1'b1}}; // R06
    assign rst_nxt = ((rst_r & rst_keep) | rst_set) & RST_FLAG_MASK; // R04

    // Runs on power-on reset only, so the cause survives every later reset
    always_ff @(posedge ref_clk or negedge por_n)
    begin
        if (!por_n)
            rst_r <= RST_CAUSE_POR; // R05
        else
            rst_r <= rst_nxt;
    end

    // ****************************************
    // Read data
    // ****************************************
    assign rd_data = rd_nmi ? {{(32-NMI_W){1'b0}}, nmi_r} : // R03
                     rd_rst ? {{(32-RST_W){1'b0}}, rst_r} : 32'h0000_0000; // R04

    // ****************************************
    // Write channel
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
            begin
                awready_r <= 1'b0;
                aw_held_r <= 1'b1;
                waddr_r <= (s_axi_awaddr[31:ADDR_W] == '0) ?
                           s_axi_awaddr[ADDR_W-1:0] : 4'hF;
            end
            if (w_hs)
            begin
                wready_r <= 1'b0;
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            // Writes to the read-only NMI word are ignored but answered OKAY
            if (do_wr)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_hs)
            begin
                bvalid_r <= 1'b0;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end
        else
        begin
            if (ar_hs)
            begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= rd_data; // R02
                rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (r_hs)
            begin
                arready_r <= 1'b1;
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ****************************************
    // Assertions
    // ****************************************
    AST_NMI_WDT_SET: assert property ( // R01
        @(posedge ref_clk) disable iff (!resetn)
        wdt_nmi |=> nmi_r[NMI_WDT_BIT])
        else $error("watchdog NMI did not set its cause flag");

    AST_NMI_PIN_SET: assert property ( // R01
        @(posedge ref_clk) disable iff (!resetn)
        $rose(nmi_pin) ##3 (pin_s3_r && !pin_lvl_r) |=> nmi_r[NMI_PIN_BIT])
        else $error("NMI pin edge did not set its cause flag");

    AST_NMI_RD_CLR: assert property ( // R02
        @(posedge ref_clk) disable iff (!resetn)
        (nmi_rd_clr && !wdt_nmi && !pin_rise) |=>
        (nmi_r == NMI_CAUSE_RST) && rvalid_r && (rdata_r[NMI_W-1:0] == $past(nmi_r)))
        else $error("NMI cause read did not return and clear the flags");

    AST_NMI_HIGH_ZERO: assert property ( // R03
        @(posedge ref_clk) disable iff (!resetn)
        nmi_rd_clr |=> (rdata_r[31:NMI_W] == '0) && (rresp_r == RESP_OKAY))
        else $error("NMI cause read shows nonzero upper bits");

    AST_RST_WR_CLEAR: assert property ( // R04
        @(posedge ref_clk) disable iff (!resetn)
        (wr_lane0 && !wdata_r[RST_WDT_BIT] && !rst_src.watchdog) |=> !rst_r[RST_WDT_BIT])
        else $error("writing zero did not clear the watchdog reset flag");

    AST_RST_CORE_SET: assert property ( // R04
        @(posedge ref_clk) disable iff (!por_n)
        rst_src.core_req |=> rst_r[RST_CORE_BIT] ##1 1'b1)
        else $error("core reset request did not set its flag");

    AST_RST_RD_ZERO: assert property ( // R04
        @(posedge ref_clk) disable iff (!resetn)
        (ar_hs && rd_rst) |=> (rdata_r[31:RST_W] == '0) && !rdata_r[RST_ZERO_BIT])
        else $error("reset cause read shows a bit that must be zero");

    AST_RST_KEEP: assert property ( // R05
        @(posedge ref_clk) disable iff (!por_n)
        (!resetn && !(|rst_src)) |=> $stable(rst_r))
        else $error("a later reset changed the reset cause flags");

    AST_RST_NO_SW_SET: assert property ( // R06
        @(posedge ref_clk) disable iff (!resetn)
        (wr_lane0 && !(|rst_src)) |=>
        (rst_r == ($past(rst_r) & $past(wdata_r[RST_W-1:0]) & RST_FLAG_MASK)))
        else $error("software write raised a reset cause flag");

endmodule // rcf_cause_flags

// File: testbench/rcf_bus_master.sv
// AXI4-Lite master standing in for processor software
`timescale 1ns/100ps
module rcf_bus_master (
    input wire logic ref_clk,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [31:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, wdata, araddr} = 96'h0;
    end

    // Each channel drops valid only at the edge where its own ready was seen
    task automatic write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah;
        logic wh;
        ah = 1'b1;
        wh = 1'b1;
        @(posedge ref_clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        while (ah || wh)
        begin
            @(posedge ref_clk);
            if (ah && awready === 1'b1)
            begin
                ah = 1'b0;
                awvalid <= 1'b0;
            end
            if (wh && wready === 1'b1)
            begin
                wh = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule // rcf_bus_master

// File: testbench/test_rcf_cause_flags.sv
// Self-checking testbench for the NMI and reset cause flag registers
`timescale 1ns/100ps
module test_rcf_cause_flags;
    import rcf_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic por_n = 1'b0;
    logic wdt_nmi = 1'b0;
    logic nmi_pin = 1'b0;
    rcf_rst_src_t rst_src = '0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0] bresp, rresp;
    int errors = 0;
    int n_tests = 0;

    always #20 ref_clk = ~ref_clk;

    rcf_cause_flags rcf_cause_flags_i (.ref_clk(ref_clk), .resetn(resetn), .por_n(por_n),
        .wdt_nmi(wdt_nmi), .nmi_pin(nmi_pin), .rst_src(rst_src), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp));

    rcf_bus_master rcf_bus_master_i (.ref_clk(ref_clk), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_expect(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rcf_bus_master_i.read(a, d, r);
        check("read data", exp, d);
        check("read resp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic wr_expect(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        rcf_bus_master_i.write(a, d, r);
        check("write resp", {30'h0, er}, {30'h0, r});
    endtask

    // Pin stays high long enough to pass the synchroniser before it drops
    task automatic set_nmi(input logic w, input logic p);
        @(posedge ref_clk);
        wdt_nmi <= w;
        nmi_pin <= p;
        @(posedge ref_clk);
        wdt_nmi <= 1'b0;
        repeat (6) @(posedge ref_clk);
        nmi_pin <= 1'b0;
    endtask

    task automatic pulse_src(input logic [2:0] s);
        @(posedge ref_clk);
        rst_src <= rcf_rst_src_t'(s);
        @(posedge ref_clk);
        rst_src <= '0;
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        por_n <= 1'b1;
        rd_expect(32'h0, 32'h0, RESP_OKAY);
        rd_expect(32'h4, 32'h1, RESP_OKAY);
        $display("test reset values done");
        set_nmi(1'b1, 1'b0);
        rd_expect(32'h0, 32'h1, RESP_OKAY);
        rd_expect(32'h0, 32'h0, RESP_OKAY);
        set_nmi(1'b0, 1'b1);
        wr_expect(32'h0, 32'hFFFFFFFF, RESP_OKAY);
        rd_expect(32'h0, 32'h2, RESP_OKAY);
        set_nmi(1'b1, 1'b1);
        rd_expect(32'h0, 32'h3, RESP_OKAY);
        rd_expect(32'h0, 32'h0, RESP_OKAY);
        $display("test nmi cause done");
        pulse_src(3'h7);
        rd_expect(32'h4, 32'h17, RESP_OKAY);
        // Software keeps bit 3 at zero on every write to the reset cause word
        wr_expect(32'h4, 32'hFFFFFFF7, RESP_OKAY);
        rd_expect(32'h4, 32'h17, RESP_OKAY);
        wr_expect(32'h4, 32'hFFFFFFE6, RESP_OKAY);
        rd_expect(32'h4, 32'h06, RESP_OKAY);
        // Ones written over cleared flags must not raise them
        wr_expect(32'h4, 32'hFFFFFFF7, RESP_OKAY);
        rd_expect(32'h4, 32'h06, RESP_OKAY);
        wr_expect(32'h4, 32'h0, RESP_OKAY);
        rd_expect(32'h4, 32'h0, RESP_OKAY);
        $display("test reset cause done");
        pulse_src(3'h1);
        set_nmi(1'b1, 1'b0);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_expect(32'h4, 32'h2, RESP_OKAY);
        // Lane 0 off: the byte that holds every flag is left alone
        wstrb <= 4'hE;
        wr_expect(32'h4, 32'h0, RESP_OKAY);
        rd_expect(32'h4, 32'h2, RESP_OKAY);
        wstrb <= 4'hF;
        rd_expect(32'h0, 32'h0, RESP_OKAY);
        $display("test warm reset done");
        rd_expect(32'h8, 32'h0, RESP_SLVERR);
        wr_expect(32'h8, 32'hFFFFFFFF, RESP_SLVERR);
        rd_expect(32'h4, 32'h2, RESP_OKAY);
        $display("test unmapped access done");
        finish_test();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge ref_clk);
        errors++;
        finish_test();
    end
endmodule // test_rcf_cause_flags
